/* File: scpg_top.sv */
`timescale 1ns/1ps
module scpg_top #(
  parameter int unsigned WORD_W = scpg_pkg::WORD_W,
  parameter int unsigned CTRL_W = scpg_pkg::CTRL_W
) (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              port_enable_i,
  input  wire logic              port_select_n_i,
  input  wire logic              sclk_i,
  input  wire logic              serial_in_i,
  input  wire logic [CTRL_W-1:0] direct_ctrl_i,
  input  wire logic [WORD_W-1:0] tx_word_i,
  output logic                   serial_out_o,
  output logic                   serial_out_oe_o,
  output logic [WORD_W-1:0]      rx_word_o,
  output logic                   rx_valid_o,
  output logic [CTRL_W-1:0]      settings_o,
  output logic                   serial_mode_o
);
  // refuse widths that the shifter and the settings slice cannot serve
  if (WORD_W < 2 || WORD_W > 64 || CTRL_W < 1 || CTRL_W > WORD_W) begin : g_bad_width
    $error("scpg_top: unsupported WORD_W/CTRL_W");
  end

  typedef enum logic [1:0] {SCPG_IDLE = 2'b00, SCPG_SHIFT = 2'b01} scpg_state_t;
  localparam int unsigned CW = $clog2(WORD_W + 1);

  scpg_sync_if sy();
  scpg_sync u_sync (
    .clk_i           (clk_i),
    .rstn_i          (rstn_i),
    .port_select_n_i (port_select_n_i),
    .sclk_i          (sclk_i),
    .serial_in_i     (serial_in_i),
    .sy              (sy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // port-enable pin: two flops before any logic reads it
  logic en1_r, en1_nxt;
  logic en2_r, en2_nxt;

  always_comb begin
    en1_nxt = port_enable_i;
    en2_nxt = en1_r;
  end

  // disabled after reset, so the direct pins rule until the pin is seen high
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en1_r <= 1'b0;
      en2_r <= 1'b0;
    end else begin
      en1_r <= en1_nxt;
      en2_r <= en2_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift engine state
  scpg_state_t       st_r, st_nxt;
  logic [WORD_W-1:0] rxs_r, rxs_nxt;
  logic [WORD_W-1:0] txs_r, txs_nxt;
  logic [CW-1:0]     cnt_r, cnt_nxt;
  logic [WORD_W-1:0] rxw_r, rxw_nxt;
  logic              rxv_r, rxv_nxt;
  logic              so_r, so_nxt;
  logic              oe_r, oe_nxt;
  logic [CTRL_W-1:0] ser_r, ser_nxt;
  logic [CTRL_W-1:0] set_r, set_nxt;
  logic              active;

  // frame only counts with port enabled and select low
  assign active = en2_r & sy.sel_act; // RULE1 RULE2

  // capture on rising, drive on falling serial clock edge
  always_comb begin
    st_nxt  = st_r;
    rxs_nxt = rxs_r;
    txs_nxt = txs_r;
    cnt_nxt = cnt_r;
    rxw_nxt = rxw_r;
    rxv_nxt = 1'b0;
    so_nxt  = so_r;
    oe_nxt  = 1'b0;
    ser_nxt = ser_r;
    case (st_r)
      SCPG_IDLE: begin
        if (active) begin
          st_nxt  = SCPG_SHIFT;
          cnt_nxt = '0;
          // whole word loaded: the leading fall of an idle-high clock
          // re-drives the msb, so it stands through the first rise
          txs_nxt = tx_word_i;
          so_nxt  = tx_word_i[WORD_W-1];
          oe_nxt  = 1'b1;
        end
      end
      default: begin
        if (!active) begin
          st_nxt = SCPG_IDLE;   // RULE4 RULE5
        end else begin
          oe_nxt = 1'b1;        // RULE3
          if (sy.rise) begin
            rxs_nxt = {rxs_r[WORD_W-2:0], sy.din}; // RULE3 RULE6
            if (cnt_r == CW'(WORD_W - 1)) begin
              cnt_nxt = '0;
              rxw_nxt = {rxs_r[WORD_W-2:0], sy.din};
              rxv_nxt = 1'b1;
              ser_nxt = CTRL_W'({rxs_r[WORD_W-2:0], sy.din});
              txs_nxt = tx_word_i;
            end else begin
              cnt_nxt = cnt_r + CW'(1);
            end
          end else if (sy.fall) begin
            so_nxt  = txs_r[WORD_W-1]; // RULE3 RULE6
            txs_nxt = {txs_r[WORD_W-2:0], 1'b0};
          end
        end
      end
    endcase
    // serial settings only when the port is enabled, else the direct pins
    set_nxt = en2_r ? ser_r : direct_ctrl_i; // RULE1 RULE2
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r  <= SCPG_IDLE;
      rxs_r <= '0;
      txs_r <= '0;
      cnt_r <= '0;
      rxw_r <= '0;
      rxv_r <= 1'b0;
      so_r  <= 1'b0;
      oe_r  <= 1'b0;
      ser_r <= CTRL_W'(scpg_pkg::CTRL_RST);
      set_r <= CTRL_W'(scpg_pkg::CTRL_RST);
    end else begin
      st_r  <= st_nxt;
      rxs_r <= rxs_nxt;
      txs_r <= txs_nxt;
      cnt_r <= cnt_nxt;
      rxw_r <= rxw_nxt;
      rxv_r <= rxv_nxt;
      so_r  <= so_nxt;
      oe_r  <= oe_nxt;
      ser_r <= ser_nxt;
      set_r <= set_nxt;
    end
  end

  assign serial_out_o    = so_r;
  assign serial_out_oe_o = oe_r; // RULE5
  assign rx_word_o       = rxw_r;
  assign rx_valid_o      = rxv_r;
  assign settings_o      = set_r;
  assign serial_mode_o   = en2_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_idle_sel;
    !sy.sel_act;
  endsequence

  // a frame opens while the engine is idle
  sequence s_frame_start;
    st_r == SCPG_IDLE && active;
  endsequence

  // rising edge that completes a word
  sequence s_last_rise;
    st_r == SCPG_SHIFT && active && sy.rise && cnt_r == CW'(WORD_W - 1);
  endsequence

  // falling edge inside an open frame
  sequence s_fall_in_frame;
    st_r == SCPG_SHIFT && active && sy.fall;
  endsequence

  // select released or port disabled after an open frame
  sequence s_frame_end;
    active ##1 !active;
  endsequence

  a_oe_off_idle: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE5
    s_idle_sel |=> !serial_out_oe_o) else $error("output driven with select deasserted");
  a_oe_off_disabled: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE2
    !en2_r |=> !serial_out_oe_o) else $error("output driven with port disabled");
  a_no_capture_idle: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE4
    !active |=> $stable(rxs_r)) else $error("bit captured outside frame");
  a_capture_edge: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE6
    $changed(rxs_r) |-> $past(sy.rise)) else $error("capture without clock edge");
  a_capture_bit: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE3
    (st_r == SCPG_SHIFT && active && sy.rise) |=> rxs_r[0] == $past(sy.din))
    else $error("wrong bit captured");
  a_drive_in_frame: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE3
    active [*2] |-> serial_out_oe_o) else $error("output not driven in frame");
  a_settings_direct: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE2
    !en2_r |=> settings_o == $past(direct_ctrl_i)) else $error("direct pins not followed");
  a_settings_serial: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE1
    en2_r |=> settings_o == $past(ser_r)) else $error("direct pins not disregarded");

  // first bit must stand before the host's first clock edge
  a_frame_first_bit: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE3
    s_frame_start |=> serial_out_oe_o && serial_out_o == $past(tx_word_i[WORD_W-1]))
    else $error("first bit not driven at frame start");

  // word handed over right after its last bit
  a_word_done: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE3
    s_last_rise |=> rx_valid_o && rx_word_o == $past({rxs_r[WORD_W-2:0], sy.din}))
    else $error("word not handed over after last bit");

  // strobe lasts one cycle only
  a_valid_pulse: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE3
    rx_valid_o |=> !rx_valid_o) else $error("word strobe longer than one cycle");

  // next bit goes out on a falling edge
  a_drive_fall: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE6
    s_fall_in_frame |=> serial_out_o == $past(txs_r[WORD_W-1]))
    else $error("bit not driven on falling edge");

  // output moves only at frame start or on a falling edge
  a_out_moves: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE6
    $changed(serial_out_o) |-> $past((st_r == SCPG_IDLE && active) || sy.fall))
    else $error("serial output moved without a falling edge");

  // line released once the frame closes
  a_oe_frame_end: assert property (@(posedge clk_i) disable iff (!rstn_i) // RULE5
    s_frame_end |=> !serial_out_oe_o)
    else $error("output still driven after frame end");
endmodule

/* File: scpg_pkg.sv */
// Overview of operation
// RULE1 - with the port-enable input high the serial port runs and the direct control pins are disregarded.
// RULE2 - with the port-enable input low the serial port is disabled and settings come from the direct pins.
// RULE3 - while the select is asserted the serial clock captures bits from serial_in and drives serial_out.
// RULE4 - while the select is deasserted serial_in is ignored and no bit is captured.
// RULE5 - while the select is deasserted serial_out floats so others may share the line.
// RULE6 - all serial bits move in step with the host-supplied serial clock; the code drives the first serial_out bit at frame start, before any edge.
// RULE7 - the host drives the select low to assert it and high to end a transfer.
package scpg_pkg;
  localparam int unsigned WORD_W     = 8;     // default shift word width
  localparam int unsigned CTRL_W     = 8;     // default direct/serial settings width
  localparam logic [7:0]  CTRL_RST   = 8'h00; // settings reset value
  localparam logic [2:0]  SYNC_RST   = 3'h7;  // idle pin levels: select high, clock high
endpackage

/* File: scpg_sync_if.sv */
`timescale 1ns/1ps
// synchronised pin levels and edge strobes
interface scpg_sync_if;
  logic sel_act;  // select asserted
  logic rise;     // serial clock rising edge
  logic fall;     // serial clock falling edge
  logic din;      // synchronised serial_in
  modport src (output sel_act, rise, fall, din);
  modport dst (input sel_act, rise, fall, din);
endinterface

/* File: scpg_sync.sv */
`timescale 1ns/1ps
module scpg_sync (
  input  wire logic   clk_i,
  input  wire logic   rstn_i,
  input  wire logic   port_select_n_i,
  input  wire logic   sclk_i,
  input  wire logic   serial_in_i,
  scpg_sync_if.src    sy
);
  logic [2:0] s1_r, s1_nxt;
  logic [2:0] s2_r, s2_nxt;
  logic       ck3_r, ck3_nxt;

  // two-stage synchronisers; first stage read only by second
  always_comb begin
    s1_nxt  = {port_select_n_i, sclk_i, serial_in_i};
    s2_nxt  = s1_r;
    ck3_nxt = s2_r[1];
  end

  // idle levels at reset, so no false clock edge follows release
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_r  <= scpg_pkg::SYNC_RST;
      s2_r  <= scpg_pkg::SYNC_RST;
      ck3_r <= scpg_pkg::SYNC_RST[1];
    end else begin
      s1_r  <= s1_nxt;
      s2_r  <= s2_nxt;
      ck3_r <= ck3_nxt;
    end
  end

  // active-low select, edges from the sampled serial clock
  assign sy.sel_act = ~s2_r[2];            // RULE7
  assign sy.rise    = s2_r[1] & ~ck3_r;    // RULE6
  assign sy.fall    = ~s2_r[1] & ck3_r;    // RULE6
  assign sy.din     = s2_r[0];
endmodule

/* File: scpg_host.sv */
`timescale 1ns/1ps
// host model: drives select, clock and data; the clock idles high between frames
module scpg_host (
  output logic      sel_n_o,
  output logic      sclk_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  logic [7:0] got;
  initial begin
    sel_n_o = 1'b1;
    sclk_o  = 1'b1;
    sdi_o   = 1'b0;
    got     = 8'h00;
  end
  // n bits msb first; act low runs the clock with the port left unselected
  // sdo is sampled just before each fall after the first and once after the last rise, well after the device has moved it
  task automatic xfer(input logic [7:0] w, input int n, input logic act);
    sel_n_o = ~act;
    #200;
    for (int k = 0; k < n; k++) begin
      if (k > 0) got = {got[6:0], sdo_i};
      sclk_o = 1'b0;
      sdi_o  = w[7-k];
      #100;
      sclk_o = 1'b1;
      #100;
    end
    got = {got[6:0], sdo_i};
    #100;
    sel_n_o = 1'b1;
    sdi_o   = ~sdi_o; // released line shows no stale bit
    #200;
  endtask
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  logic       clk_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic       en = 1'b0;
  logic [7:0] dct = 8'h00;
  logic [7:0] tx = 8'h00;
  logic [7:0] w, rxw, st;
  logic       sel_n, sclk, serial_in, so, oe, rxv, mode;
  int         mismatches = 0;
  int         compares = 0;
  int         seed = 16941;
  int         pulses = 0;
  int         cyc = 0;
  int         p;
  // a floating data line reads as the inverse of the last bit, so a stale bit cannot pass
  scpg_host i_host (.sel_n_o(sel_n), .sclk_o(sclk), .sdi_o(serial_in), .sdo_i(oe ? so : ~so));
  scpg_top i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .port_enable_i(en), .port_select_n_i(sel_n),
    .sclk_i(sclk), .serial_in_i(serial_in), .direct_ctrl_i(dct), .tx_word_i(tx), .serial_out_o(so),
    .serial_out_oe_o(oe), .rx_word_o(rxw), .rx_valid_o(rxv), .settings_o(st), .serial_mode_o(mode));
  initial forever #12.5 clk_i = ~clk_i;
  // count word strobes; a hang is cut short by the cycle ceiling
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (rxv === 1'b1) pulses <= pulses + 1;
    if (cyc == 5000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // settings expected from the port mode: serial word when enabled, else the pins
  function automatic logic [7:0] exp_set(input logic e, input logic [7:0] word, input logic [7:0] pins);
    return e ? word : pins;
  endfunction
  task automatic finish_test();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic settle();
    repeat (8) @(posedge clk_i);
    #2;
  endtask
  // one framed word, oe looked at mid-frame
  task automatic frame(input logic [7:0] d, input int n);
    p = pulses;
    fork
      i_host.xfer(d, n, 1'b1);
      begin
        #600;
        chk({7'h00, oe}, {7'h00, en}, "oe in frame");
      end
    join
    settle();
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    chk(st, 8'h00, "reset settings");
    chk({5'h00, oe, rxv, mode}, 8'h00, "reset flags");
    #2 rstn_i = 1'b1;
    // random frames in both modes, all-zero and all-one words among them
    for (int k = 0; k < 8; k++) begin
      en  = k[0];
      dct = 8'($random(seed));
      tx  = (k == 5) ? 8'h81 : 8'($random(seed));
      w   = (k == 3) ? 8'hff : (k == 1) ? 8'h00 : 8'($random(seed));
      settle();
      chk({7'h00, mode}, {7'h00, en}, "mode");
      frame(w, 8);
      chk(8'(pulses - p), {7'h00, en}, "word count");
      chk({7'h00, oe}, 8'h00, "oe idle");
      if (en) begin
        chk(rxw, w, "rx word");
        chk(i_host.got, tx, "tx bits");
        dct = ~dct;
        settle();
        chk(st, exp_set(en, w, dct), "serial settings");
      end else begin
        chk(st, exp_set(en, w, dct), "direct settings");
      end
    end
    // clocks with select high, then a cut-short word, then a clean word
    p = pulses;
    fork
      i_host.xfer(~w, 8, 1'b0);
      begin
        #600;
        chk({7'h00, oe}, 8'h00, "oe unselected");
      end
    join
    settle();
    chk(8'(pulses - p), 8'h00, "unselected strobe");
    chk(rxw, w, "unselected word");
    frame(8'h5a, 5);
    chk(8'(pulses - p), 8'h00, "partial strobe");
    frame(8'h3c, 8);
    chk(rxw, 8'h3c, "after partial");
    chk(i_host.got, tx, "tx after partial");
    chk(st, exp_set(en, 8'h3c, dct), "settings after partial");
    finish_test();
  end
endmodule
